/* shared/swss_pkg.sv */
// Constants, timing figures and state types of the single-wire slave.
package swss_pkg;

   // -------------------------------------------------------------------
   // Clock and timing
   // -------------------------------------------------------------------
   localparam int CLK_NS = 40;
   localparam int TW     = 14;

   // Rounds a least time up to whole cycles, never below one.
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction

   // Low time that always clears the fast speed flag.
   localparam int RST_LONG_NS = 480000;
   // Low time after which a low level is taken as a reset.
   localparam int RST_STD_NS  = 120000;
   localparam int RST_OVD_NS  = 16000;
   // Presence wait and presence low times.
   localparam int PW_STD_NS   = 15000;
   localparam int PW_OVD_NS   = 2000;
   localparam int PL_STD_NS   = 60000;
   localparam int PL_OVD_NS   = 8000;
   // Write sample point, which is also the end of a read-zero pulldown.
   localparam int DATA_STD_NS = 30000;
   localparam int DATA_OVD_NS = 3000;
   // Slot recovery time.
   localparam int REC_STD_NS  = 5000;
   localparam int REC_OVD_NS  = 2000;

   // -------------------------------------------------------------------
   // Commands and counts
   // -------------------------------------------------------------------
   localparam logic [7:0] CMD_SKIP   = 8'hcc;
   localparam logic [7:0] CMD_RESUME = 8'ha5;
   localparam logic [7:0] CMD_OSKIP  = 8'h3c;
   localparam logic [7:0] CMD_MATCH  = 8'h55;
   localparam logic [7:0] CMD_OMATCH = 8'h69;
   localparam logic [7:0] CMD_SEARCH = 8'hf0;

   localparam int         BYTE_BITS  = 8;
   localparam int         ID_BITS    = 64;
   localparam int         FIFO_DEPTH = 16;
   localparam logic [5:0] ID_LAST    = 6'h3f;
   localparam logic [5:0] BYTE_LAST  = 6'h07;
   localparam logic [1:0] TRI_WR     = 2'h2;

   // -------------------------------------------------------------------
   // State types
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      L_IDLE  = 3'h0,
      L_LOW   = 3'h1,
      L_REC   = 3'h3,
      L_PWAIT = 3'h5,
      L_PLOW  = 3'h7
   } swss_link_t;

   typedef enum logic [2:0] {
      P_CMD   = 3'h0,
      P_MATCH = 3'h1,
      P_SRCH  = 3'h3,
      P_MEM   = 3'h2,
      P_WAIT  = 3'h6
   } swss_phase_t;

endpackage

/* shared/swss_strm_if.sv */
// Valid/ready byte stream between the slot logic and its FIFO.
`timescale 1ns/1ps
`default_nettype none
interface swss_strm_if #(parameter int W = 8);
   logic [W-1:0] data;
   logic         valid;
   logic         ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

/* verification/swss_bench.sv */
// Self-checking bench for the single-wire slave.
`timescale 1ns/1ps
`default_nettype none
module swss_bench import swss_pkg::*; ;
   // Identity value is arbitrary; mostly ones keep standard slots short.
   localparam logic [63:0] ID = 64'hf7fb_fdfe_7fbf_dfef;
   logic       clk = 1'b0;
   logic       nrst = 1'b0;
   logic       rxr = 1'b0;
   logic       txv = 1'b0;
   logic [7:0] txd = 8'h00;
   logic [7:0] v, b, rxd;
   logic       pull, oe, lo, fast, res, sel, rxv, txr, p, brs;
   logic [7:0] q[$];
   int         err_total = 0;
   int         checks = 0;
   int         nsel = 0;
   int         nrs = 0;
   int         r;
   int         i;
   wire        line = !(pull || (oe && !lo));

   swss_top #(.RST_LONG_CYC(3200), .DEV_ID(ID)) uut (
      .clk(clk), .nrst(nrst), .line_i(line), .line_o(lo), .line_oe(oe),
      .fast_speed_flag(fast), .resume_select_flag(res), .sel_strobe(sel),
      .bus_reset(brs), .rx_data(rxd), .rx_valid(rxv), .rx_ready(rxr),
      .tx_data(txd), .tx_valid(txv), .tx_ready(txr));
   swss_master m (.clk(clk), .line(line), .pull(pull));

   task automatic chk(input logic [63:0] s, input logic [63:0] e);
      checks++;
      if (s !== e) begin
         err_total++;
         $display("ERROR %0t: seen %0h, expected %0h", $time, s, e);
      end
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Reset, presence, one command and an identity where one is due.
   task automatic go(input int n, input logic [7:0] c,
                     input logic [63:0] x, input int s);
      r = nrs;
      m.rst(n, p);
      chk(p, 1'b1);
      chk(nrs, r + 1);
      m.wbyte(c);
      if (c == CMD_OMATCH) m.od = 1'b1;
      if (c == CMD_OMATCH || c == CMD_MATCH)
         for (int k = 0; k < 64; k += 8) m.wbyte(x[k+:8]);
      repeat (3) @(posedge clk);
      chk(nsel, s);
   endtask

   always @(posedge clk) begin
      if (sel === 1'b1) nsel <= nsel + 1;
      if (brs === 1'b1) nrs <= nrs + 1;
      if (rxv === 1'b1 && rxr === 1'b1) begin
         if (q.size() == 0) chk(1'b1, 1'b0);
         else chk(rxd, q.pop_front());
      end
   end

   initial forever #20 clk = ~clk;
   initial begin
      void'($urandom(86925));
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      go(3300, CMD_MATCH, ID, 1);
      chk(res, 1'b1);
      chk(fast, 1'b0);
      go(3300, CMD_RESUME, ID, 2);
      go(3300, CMD_OMATCH, ID, 3);
      chk(fast, 1'b1);
      go(500, CMD_OMATCH, ID ^ 64'h1, 3);
      chk(fast, 1'b1);
      chk(res, 1'b0);
      go(500, CMD_RESUME, ID, 3);
      chk(fast, 1'b1);
      m.rst(3300, p);
      chk(fast, 1'b0);
      go(3300, CMD_OSKIP, ID, 4);
      m.od = 1'b1;
      chk(fast, 1'b1);
      // One byte more than the buffer holds waits until room appears.
      for (i = 0; i < 17; i++) begin
         v = 8'($urandom);
         q.push_back(v);
         m.wbyte(v);
      end
      chk(rxv, 1'b1);
      rxr <= 1'b1;
      for (i = 0; i < 60 && q.size() > 0; i++) @(posedge clk);
      chk(q.size(), 0);
      v = 8'($urandom);
      txd <= v;
      txv <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (txr === 1'b1) break;
      end
      txv <= 1'b0;
      if (i == 20) begin
         err_total++;
         close_out();
      end
      m.rbyte(b);
      chk(b, v);
      // After a fast skip, a fast reset and a match pick out one device.
      go(500, CMD_MATCH, ID, 5);
      chk(res, 1'b1);
      go(500, CMD_SKIP, ID, 6);
      chk(fast, 1'b1);
      close_out();
   end
endmodule
`default_nettype wire

/* verification/swss_master.sv */
// Bus master model driving the shared open-drain line.
`timescale 1ns/1ps
`default_nettype none
module swss_master (
   // Clock and line
   input  wire logic clk,
   input  wire logic line,
   output logic      pull
);
   logic od = 1'b0;
   initial pull = 1'b0;
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Zero slots stay low well past the device sample point.
   task automatic wbit(input logic b);
      pull <= 1'b1;
      hold(b ? 10 : (od ? 90 : 780));
      pull <= 1'b0;
      hold(od ? 70 : 150);
   endtask
   task automatic wbyte(input logic [7:0] v);
      for (int i = 0; i < 8; i++) wbit(v[i]);
   endtask
   task automatic rbyte(output logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         pull <= 1'b1;
         hold(6);
         pull <= 1'b0;
         hold(od ? 30 : 60);
         v[i] = line;
         hold(od ? 120 : 900);
      end
   endtask
   task automatic rst(input int n, output logic p);
      pull <= 1'b1;
      hold(n);
      pull <= 1'b0;
      if (n > 3200) od = 1'b0;
      hold(od ? 120 : 600);
      p = !line;
      // A single device needs only presence plus recovery here.
      hold(od ? 250 : 1450);
   endtask
endmodule
`default_nettype wire

/* verilog/swss_fifo.sv */
// Byte FIFO between the received slot data and the memory function layer.
`timescale 1ns/1ps
`default_nettype none
module swss_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         nrst,
   // Fill side
   swss_strm_if.snk          wr,
   // Drain side
   output logic [W-1:0]      rd_data,
   output logic              rd_valid,
   input  wire logic         rd_ready
);
   localparam int AW = $clog2(D);

   logic [W-1:0] mem [D];
   logic [AW:0]  wp_q;
   logic [AW:0]  wp_d;
   logic [AW:0]  rp_q;
   logic [AW:0]  rp_d;
   logic         full;
   logic         push;
   logic         pop;

   always_comb begin
      full     = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
      rd_valid = (wp_q != rp_q);
      wr.ready = !full;
      push     = wr.valid && !full;
      pop      = rd_valid && rd_ready;
      wp_d     = push ? wp_q + (AW+1)'(1) : wp_q;
      rp_d     = pop ? rp_q + (AW+1)'(1) : rp_q;
      rd_data  = mem[rp_q[AW-1:0]];
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
      end
      if (push) begin
         mem[wp_q[AW-1:0]] <= wr.data;
      end
   end

   a_fifo_full: assert property (@(posedge clk) disable iff (!nrst)
      full |=> wp_q == $past(wp_q))
      else $error("FIFO accepted a word while full");
endmodule
`default_nettype wire

/* verilog/swss_sync.sv */
// Two-stage synchroniser for the bus line level.
`timescale 1ns/1ps
`default_nettype none
module swss_sync (
   // Clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   // Level
   input  wire logic d,
   output logic      q
);
   logic s1_q;
   logic s1_d;
   logic q_d;

   always_comb begin
      s1_d = d;
      q_d  = s1_q;
   end

   // Both stages reset to the idle-high level of the line.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         s1_q <= 1'b1;
         q    <= 1'b1;
      end else begin
         s1_q <= s1_d;
         q    <= q_d;
      end
   end
endmodule
`default_nettype wire

/* verilog/swss_top.sv */
// Single-wire slave: selection commands, speed, reset/presence and slots.
//
// How it works
// - Command CCh after presence hands over to the memory layer without identity.
// - Command A5h hands over only if the resume-select flag is set.
// - Only identity match, search or overdrive match set resume-select.
// - A selection addressing another device clears the resume-select flag.
// - Command 3Ch sets the fast speed flag and hands over directly.
// - A reset low of 480us or more clears the fast speed flag.
// - At fast speed a short reset keeps the fast speed flag set.
// - Command 69h takes 64 identity bits fast; full match sets fast speed.
// - A failed overdrive match leaves an already set fast speed flag set.
// - Standard timing by default; fast timing for all waveforms when flagged.
// - The master makes every falling edge except presence.
// - After reset release wait the presence wait, then drive presence low.
// - Slots are accepted once presence and recovery are over.
// - Each slot carries one bit, write from master, read to master.
// - Each slot fall starts a timer setting sample point and hold time.
// - After a slot the device ignores new slots until recovery ends.
// - A read zero is pulled low until the timer ends; one not driven.
// - Command 55h with matching 64 identity bits selects; others wait reset.
// - Search sends true bit, complement, then takes master bit, LSB first.
`timescale 1ns/1ps
`default_nettype none
module swss_top import swss_pkg::*; #(
   parameter int          RST_LONG_CYC = cyc_up(RST_LONG_NS),
   // Identity value is arbitrary.
   parameter logic [63:0] DEV_ID       = 64'h5a5a_0f0f_3c3c_1e1e
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // Bus line, open drain
   input  wire logic       line_i,
   output logic            line_o,
   output logic            line_oe,
   // Selection state
   output logic            fast_speed_flag,
   output logic            resume_select_flag,
   output logic            sel_strobe,
   output logic            bus_reset,
   // Received bytes to the memory layer
   output logic [7:0]      rx_data,
   output logic            rx_valid,
   input  wire logic       rx_ready,
   // Bytes to send in read slots
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   output logic            tx_ready
);

   // -------------------------------------------------------------------
   // Line input and speed dependent counts
   // -------------------------------------------------------------------
   logic          line_s;
   logic          fast;
   logic [TW-1:0] c_rst;
   logic [TW-1:0] c_data;
   logic [TW-1:0] c_rec;
   logic [TW-1:0] c_pw;
   logic [TW-1:0] c_pl;

   function automatic logic [TW-1:0] pick(input logic f, input int s_ns,
                                          input int o_ns);
      return TW'(cyc_up(f ? o_ns : s_ns));
   endfunction

   swss_sync u_sync (
      .clk  (clk),
      .nrst (nrst),
      .d    (line_i),
      .q    (line_s)
   );

   logic od_q;
   logic ovm_q;

   always_comb begin
      fast   = od_q | ovm_q;
      c_rst  = pick(fast, RST_STD_NS, RST_OVD_NS);
      c_data = pick(fast, DATA_STD_NS, DATA_OVD_NS);
      c_rec  = pick(fast, REC_STD_NS, REC_OVD_NS);
      c_pw   = pick(fast, PW_STD_NS, PW_OVD_NS);
      c_pl   = pick(fast, PL_STD_NS, PL_OVD_NS);
   end

   // -------------------------------------------------------------------
   // Link timing: slots, reset detection and presence
   // -------------------------------------------------------------------
   swss_link_t    ls_q;
   swss_link_t    ls_d;
   logic [TW-1:0] tm_q;
   logic [TW-1:0] tm_d;
   logic          drv_q;
   logic          drv_d;
   logic          slot_end;
   logic          bit_v;
   logic          rst_ev;
   logic          rst_long;
   logic          send_en;
   logic          send_bit;

   always_comb begin
      ls_d     = ls_q;
      tm_d     = (&tm_q) ? tm_q : tm_q + TW'(1);
      drv_d    = drv_q;
      slot_end = 1'b0;
      bit_v    = 1'b0;
      rst_ev   = 1'b0;
      rst_long = 1'b0;
      case (ls_q)
         L_IDLE: begin
            // A level test, so a slot opened late in recovery is not lost.
            if (!line_s) begin
               ls_d  = L_LOW;
               tm_d  = '0;
               drv_d = send_en && !send_bit;
            end
         end
         L_LOW: begin
            if (drv_q && tm_q >= c_data) begin
               drv_d = 1'b0;
            end
            if (line_s && !drv_q) begin
               tm_d = '0;
               if (tm_q >= c_rst) begin
                  rst_ev   = 1'b1;
                  rst_long = (tm_q >= TW'(RST_LONG_CYC));
                  ls_d     = L_PWAIT;
               end else begin
                  // A rise before the sample point is a one.
                  slot_end = 1'b1;
                  bit_v    = (tm_q < c_data);
                  ls_d     = L_REC;
               end
            end
         end
         L_REC: begin
            if (tm_q >= c_rec) begin
               ls_d = L_IDLE;
            end
         end
         L_PWAIT: begin
            if (tm_q >= c_pw) begin
               ls_d  = L_PLOW;
               tm_d  = '0;
               drv_d = 1'b1;
            end
         end
         L_PLOW: begin
            if (tm_q >= c_pl) begin
               ls_d  = L_REC;
               tm_d  = '0;
               drv_d = 1'b0;
            end
         end
         default: begin
            ls_d  = L_IDLE;
            drv_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         ls_q  <= L_IDLE;
         tm_q  <= '0;
         drv_q <= 1'b0;
      end else begin
         ls_q  <= ls_d;
         tm_q  <= tm_d;
         drv_q <= drv_d;
      end
   end

   assign line_o  = 1'b0;
   assign line_oe = drv_q;

   // -------------------------------------------------------------------
   // Selection commands and memory layer data
   // -------------------------------------------------------------------
   swss_phase_t ph_q;
   swss_phase_t ph_d;
   logic        od_d;
   logic        rc_q;
   logic        rc_d;
   logic        ovm_d;
   logic        ok_q;
   logic        ok_d;
   logic [5:0]  cnt_q;
   logic [5:0]  cnt_d;
   logic [1:0]  tri_q;
   logic [1:0]  tri_d;
   logic [7:0]  sh_q;
   logic [7:0]  sh_d;
   logic [7:0]  rxb_q;
   logic [7:0]  rxb_d;
   logic        rxv_q;
   logic        rxv_d;
   logic [7:0]  txb_q;
   logic [7:0]  txb_d;
   logic        txv_q;
   logic        txv_d;
   logic        sel_q;
   logic        sel_d;
   logic        brst_q;
   logic        brst_d;
   logic [7:0]  cmd;
   logic        id_bit;
   logic        id_hit;

   swss_strm_if #(.W(BYTE_BITS)) rx_if ();

   swss_fifo #(.W(BYTE_BITS), .D(FIFO_DEPTH)) u_fifo (
      .clk      (clk),
      .nrst     (nrst),
      .wr       (rx_if),
      .rd_data  (rx_data),
      .rd_valid (rx_valid),
      .rd_ready (rx_ready)
   );

   assign rx_if.data  = rxb_q;
   assign rx_if.valid = rxv_q;

   always_comb begin
      cmd      = {bit_v, sh_q[7:1]};
      id_bit   = DEV_ID[cnt_q];
      id_hit   = (bit_v == id_bit);
      send_en  = 1'b0;
      send_bit = 1'b1;
      case (ph_q)
         P_SRCH: begin
            send_en  = (tri_q != TRI_WR);
            send_bit = (tri_q == 2'h0) ? id_bit : !id_bit;
         end
         P_MEM: begin
            send_en  = txv_q;
            send_bit = txb_q[0];
         end
         default: begin
            send_en  = 1'b0;
         end
      endcase
      tx_ready = (ph_q == P_MEM) && !txv_q && (ls_q == L_IDLE);
   end

   always_comb begin
      ph_d   = ph_q;
      od_d   = od_q;
      rc_d   = rc_q;
      ovm_d  = ovm_q;
      ok_d   = ok_q;
      cnt_d  = cnt_q;
      tri_d  = tri_q;
      sh_d   = sh_q;
      rxb_d  = rxb_q;
      rxv_d  = rxv_q && !rx_if.ready;
      txb_d  = txb_q;
      txv_d  = txv_q;
      sel_d  = 1'b0;
      brst_d = 1'b0;
      if (tx_ready && tx_valid) begin
         txb_d = tx_data;
         txv_d = 1'b1;
      end
      if (rst_ev) begin
         ph_d   = P_CMD;
         cnt_d  = '0;
         tri_d  = '0;
         ovm_d  = 1'b0;
         txv_d  = 1'b0;
         rxv_d  = 1'b0;
         brst_d = 1'b1;
         if (rst_long) begin
            od_d = 1'b0;
         end
      end else if (slot_end) begin
         case (ph_q)
            P_CMD: begin
               sh_d  = cmd;
               cnt_d = cnt_q + 6'h01;
               if (cnt_q == BYTE_LAST) begin
                  cnt_d = '0;
                  ok_d  = 1'b1;
                  tri_d = '0;
                  case (cmd)
                     CMD_SKIP: begin
                        ph_d  = P_MEM;
                        sel_d = 1'b1;
                     end
                     CMD_RESUME: begin
                        ph_d  = rc_q ? P_MEM : P_WAIT;
                        sel_d = rc_q;
                     end
                     CMD_OSKIP: begin
                        od_d  = 1'b1;
                        ph_d  = P_MEM;
                        sel_d = 1'b1;
                     end
                     CMD_MATCH: begin
                        ph_d = P_MATCH;
                     end
                     CMD_OMATCH: begin
                        ph_d  = P_MATCH;
                        ovm_d = 1'b1;
                     end
                     CMD_SEARCH: begin
                        ph_d = P_SRCH;
                     end
                     default: begin
                        ph_d = P_WAIT;
                     end
                  endcase
               end
            end
            P_MATCH: begin
               ok_d  = ok_q && id_hit;
               cnt_d = cnt_q + 6'h01;
               if (cnt_q == ID_LAST) begin
                  ovm_d = 1'b0;
                  if (ok_q && id_hit) begin
                     rc_d  = 1'b1;
                     od_d  = od_q | ovm_q;
                     ph_d  = P_MEM;
                     sel_d = 1'b1;
                  end else begin
                     rc_d = 1'b0;
                     ph_d = P_WAIT;
                  end
               end
            end
            P_SRCH: begin
               tri_d = tri_q + 2'h1;
               if (tri_q == TRI_WR) begin
                  tri_d = '0;
                  cnt_d = cnt_q + 6'h01;
                  if (!id_hit) begin
                     rc_d = 1'b0;
                     ph_d = P_WAIT;
                  end else if (cnt_q == ID_LAST) begin
                     rc_d  = 1'b1;
                     ph_d  = P_MEM;
                     sel_d = 1'b1;
                  end
               end
            end
            P_MEM: begin
               if (txv_q) begin
                  txb_d = {1'b1, txb_q[7:1]};
                  cnt_d = cnt_q + 6'h01;
                  if (cnt_q == BYTE_LAST) begin
                     txv_d = 1'b0;
                     cnt_d = '0;
                  end
               end else if (!rxv_q) begin
                  // While a byte waits for FIFO room, write bits are dropped.
                  sh_d  = cmd;
                  cnt_d = cnt_q + 6'h01;
                  if (cnt_q == BYTE_LAST) begin
                     rxb_d = cmd;
                     rxv_d = 1'b1;
                     cnt_d = '0;
                  end
               end
            end
            default: begin
               ph_d = P_WAIT;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         ph_q   <= P_CMD;
         od_q   <= 1'b0;
         rc_q   <= 1'b0;
         ovm_q  <= 1'b0;
         ok_q   <= 1'b0;
         cnt_q  <= '0;
         tri_q  <= '0;
         sh_q   <= '0;
         rxb_q  <= '0;
         rxv_q  <= 1'b0;
         txb_q  <= '0;
         txv_q  <= 1'b0;
         sel_q  <= 1'b0;
         brst_q <= 1'b0;
      end else begin
         ph_q   <= ph_d;
         od_q   <= od_d;
         rc_q   <= rc_d;
         ovm_q  <= ovm_d;
         ok_q   <= ok_d;
         cnt_q  <= cnt_d;
         tri_q  <= tri_d;
         sh_q   <= sh_d;
         rxb_q  <= rxb_d;
         rxv_q  <= rxv_d;
         txb_q  <= txb_d;
         txv_q  <= txv_d;
         sel_q  <= sel_d;
         brst_q <= brst_d;
      end
   end

   assign fast_speed_flag    = od_q;
   assign resume_select_flag = rc_q;
   assign sel_strobe         = sel_q;
   assign bus_reset          = brst_q;

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   a_skip_handoff: assert property (@(posedge clk) disable iff (!nrst)
      slot_end && ph_q == P_CMD && cnt_q == BYTE_LAST && cmd == CMD_SKIP
      |=> sel_q && ph_q == P_MEM ##1 !sel_q)
      else $error("Skip did not hand over for one cycle");
   a_resume_gate: assert property (@(posedge clk) disable iff (!nrst)
      slot_end && ph_q == P_CMD && cnt_q == BYTE_LAST
      && cmd == CMD_RESUME |=> sel_q == $past(rc_q))
      else $error("Resume handover does not follow the flag");
   a_rc_set_src: assert property (@(posedge clk) disable iff (!nrst)
      $rose(rc_q) |-> $past(ph_q) == P_MATCH || $past(ph_q) == P_SRCH)
      else $error("Resume flag set outside match or search");
   a_rc_clear: assert property (@(posedge clk) disable iff (!nrst)
      slot_end && ph_q == P_MATCH && cnt_q == ID_LAST && !id_hit
      |=> !rc_q && ph_q == P_WAIT)
      else $error("Failed match left resume flag set");
   a_oskip_fast: assert property (@(posedge clk) disable iff (!nrst)
      slot_end && ph_q == P_CMD && cnt_q == BYTE_LAST && cmd == CMD_OSKIP
      |=> od_q && sel_q)
      else $error("Overdrive skip did not set fast speed");
   a_long_rst: assert property (@(posedge clk) disable iff (!nrst)
      ls_q == L_LOW && line_s && !drv_q && tm_q >= TW'(RST_LONG_CYC)
      |=> !od_q && ls_q == L_PWAIT)
      else $error("Long reset did not clear fast speed");
   a_short_rst: assert property (@(posedge clk) disable iff (!nrst)
      rst_ev && !rst_long && od_q |=> od_q ##1 od_q)
      else $error("Short reset dropped fast speed");
   a_omatch_keep: assert property (@(posedge clk) disable iff (!nrst)
      slot_end && ph_q == P_MATCH && od_q |=> od_q)
      else $error("Overdrive match dropped fast speed");
   a_presence_len: assert property (@(posedge clk) disable iff (!nrst)
      $fell(drv_q) && $past(ls_q) == L_PLOW |-> $past(tm_q) >= $past(c_pl))
      else $error("Presence pulse too short");
   a_read_release: assert property (@(posedge clk) disable iff (!nrst)
      ls_q == L_LOW && drv_q && tm_q >= c_data |=> !drv_q)
      else $error("Read zero held past its timer");
   a_rec_ignore: assert property (@(posedge clk) disable iff (!nrst)
      ls_q == L_REC && tm_q < c_rec |=> ls_q != L_LOW)
      else $error("Slot accepted during recovery");
endmodule
`default_nettype wire
